// *** rtl/interval_timer_pkg.sv ***
package interval_timer_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_PRESCALE = 4'h1;
  localparam logic [3:0] ADDR_PERIOD = 4'h2;
  localparam logic [3:0] ADDR_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 16;
  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_RUNNING_BIT = 0;
  localparam int STAT_ZERO_BIT = 1;
  // values after reset
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic CTRL_ENABLE_RESET = 1'b0;
  // timer run state
  typedef enum logic [0:0] {TIMER_IDLE, TIMER_RUN} timer_state_t;
endpackage

// *** rtl/prescale_divider.sv ***
`timescale 1ns/100ps
// prescale divider: one tick every (prescale+1) cycles while running
module prescale_divider #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic [WIDTH-1:0] prescale,
  output logic tick
);
  logic [WIDTH-1:0] scaleCount;

  initial begin
    if (WIDTH < 1) begin
      $error("prescale width must be at least one");
    end
  end

  // down-count, reload from prescale each time it expires
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scaleCount <= '0;
    end else if (!run) begin
      scaleCount <= prescale;
    end else if (scaleCount == '0) begin
      scaleCount <= prescale;
    end else begin
      scaleCount <= scaleCount - 1'b1;
    end
  end

  assign tick = run && (scaleCount == '0);
endmodule // prescale_divider

// *** rtl/prescaled_interval_timer.sv ***
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
// Operation
// R1: a 16-bit down-counter decrements by one every n clock cycles while the timer runs.
// R2: n comes from the 8-bit prescale register written by software, as prescale plus one cycles.
// R3: a timer interrupt request is raised when the counter reaches zero.
// R4: on reaching zero the counter reloads from the 16-bit period register.
// R5: counting proceeds on each prescaled tick on its own, never stalling the register port.
// R6: the interrupt leaves as its own dedicated request line to the interrupt logic.
// R7: a software enable bit starts the timer, and the prescaler reloads on each expiry.
module prescaled_interval_timer #(
  parameter int COUNT_WIDTH = 16,
  parameter int SCALE_WIDTH = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [interval_timer_pkg::ADDR_WIDTH-1:0] address,
  input wire logic [interval_timer_pkg::DATA_WIDTH-1:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [interval_timer_pkg::DATA_WIDTH-1:0] readData,
  output logic timerIrq
);
  import interval_timer_pkg::*;

  logic [15:0] timer_count_value;
  logic [7:0] timer_prescale_value;
  logic [15:0] timer_reload_period;
  logic enable;
  logic zeroSeen;
  logic tick;
  timer_state_t state;
  logic [DATA_WIDTH-1:0] next_readData;

  initial begin
    if (COUNT_WIDTH != 16 || SCALE_WIDTH != 8) begin
      $error("timer supports a 16-bit count and 8-bit prescale only");
    end
  end

  // run state follows the enable bit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= TIMER_IDLE;
    end else begin
      case (state)
        TIMER_IDLE: begin
          if (enable) begin
            state <= TIMER_RUN;
          end
        end
        TIMER_RUN: begin
          if (!enable) begin
            state <= TIMER_IDLE;
          end
        end
        default: begin
          state <= TIMER_IDLE;
        end
      endcase
    end
  end

  // R2: prescaled tick source
  // R7: prescaler reload on expiry
  prescale_divider #(
    .WIDTH(SCALE_WIDTH)
  ) divider (
    .clock(clock),
    .rstn(rstn),
    .run(state == TIMER_RUN),
    .prescale(timer_prescale_value),
    .tick(tick)
  );

  // prescale and period registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_prescale_value <= PRESCALE_RESET;
      timer_reload_period <= PERIOD_RESET;
    end else if (writeStrobe) begin
      if (address == ADDR_PRESCALE) begin
        timer_prescale_value <= writeData[7:0];
      end
      if (address == ADDR_PERIOD) begin
        timer_reload_period <= writeData;
      end
    end
  end

  // R7: software enable bit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enable <= CTRL_ENABLE_RESET;
    end else if (writeStrobe && address == ADDR_CONTROL) begin
      enable <= writeData[CTRL_ENABLE_BIT];
    end
  end

  // down-counter; software write takes priority over a tick
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_count_value <= COUNT_RESET;
    end else if (writeStrobe && address == ADDR_COUNT) begin
      timer_count_value <= writeData;
    end else if (tick) begin
      // R4: reload at zero
      if (timer_count_value == 16'h0000) begin
        timer_count_value <= timer_reload_period;
      end else begin
        // R1: decrement per tick
        // R5: runs beside bus traffic
        timer_count_value <= timer_count_value - 16'h0001;
      end
    end
  end

  // R3: one-cycle request at zero
  // R6: dedicated request line
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= tick && (timer_count_value == 16'h0000);
    end
  end

  // sticky zero flag; set wins over a clear by reading status
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      zeroSeen <= 1'b0;
    end else if (tick && timer_count_value == 16'h0000) begin
      zeroSeen <= 1'b1;
    end else if (readStrobe && address == ADDR_STATUS) begin
      zeroSeen <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    next_readData = '0;
    case (address)
      ADDR_COUNT: next_readData = timer_count_value;
      ADDR_PRESCALE: next_readData = {8'h00, timer_prescale_value};
      ADDR_PERIOD: next_readData = timer_reload_period;
      ADDR_CONTROL: next_readData[CTRL_ENABLE_BIT] = enable;
      ADDR_STATUS: begin
        next_readData[STAT_RUNNING_BIT] = (state == TIMER_RUN);
        next_readData[STAT_ZERO_BIT] = zeroSeen;
      end
      default: next_readData = '0;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readData <= '0;
    end else if (readStrobe) begin
      readData <= next_readData;
    end else begin
      readData <= '0;
    end
  end
endmodule // prescaled_interval_timer

// *** tb/interval_timer_properties.sv ***
`timescale 1ns/100ps
module interval_timer_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [interval_timer_pkg::ADDR_WIDTH-1:0] address,
  input wire logic [interval_timer_pkg::DATA_WIDTH-1:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [interval_timer_pkg::DATA_WIDTH-1:0] readData,
  input wire logic timerIrq
);
  import interval_timer_pkg::*;
  logic en;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // shadow of the enable bit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) en <= 1'b0;
    else if (writeStrobe && address == ADDR_CONTROL) en <= writeData[0];
  end
  // write then read of one index
  sequence wrRd(logic [3:0] a);
    writeStrobe && address == a ##1 readStrobe && address == a;
  endsequence
  // enable write, two quiet cycles, status read
  sequence ctlRd(logic v);
    writeStrobe && address == ADDR_CONTROL && writeData[0] == v ##1 !writeStrobe [*2] ##1
      readStrobe && address == ADDR_STATUS;
  endsequence
  a_period_readback: assert property (wrRd(ADDR_PERIOD) |=> readData == $past(writeData, 2))
    else $error("period readback");
  a_scale_readback: assert property (wrRd(ADDR_PRESCALE) |=> readData == ($past(writeData, 2) & 16'h00ff))
    else $error("prescale readback");
  a_idle_zero: assert property (!$past(readStrobe) |-> readData == 16'h0000)
    else $error("data outside read");
  a_unmapped_zero: assert property (readStrobe && address > ADDR_STATUS |=> readData == 16'h0000)
    else $error("unmapped read");
  a_irq_enabled: assert property (timerIrq |-> $past(en, 2))
    else $error("irq while off");
  a_run_status: assert property (ctlRd(1'b1) |=> readData[STAT_RUNNING_BIT])
    else $error("running not set");
  a_stop_status: assert property (ctlRd(1'b0) |=> !readData[STAT_RUNNING_BIT])
    else $error("running not cleared");
endmodule // interval_timer_checker
bind prescaled_interval_timer interval_timer_checker chk_u (.clock(clock), .rstn(rstn), .address(address),
  .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .timerIrq(timerIrq));

// *** tb/prescaled_interval_timer_tb.sv ***
`timescale 1ns/100ps
module prescaled_interval_timer_tb;
  import interval_timer_pkg::*;
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  localparam row_t ROWS [5] = '{'{ADDR_COUNT, 16'h1234, 16'h1234}, '{ADDR_PRESCALE, 16'hffab, 16'h00ab},
    '{ADDR_PERIOD, 16'hbeef, 16'hbeef}, '{ADDR_STATUS, 16'hffff, 16'h0000}, '{4'h9, 16'h5555, 16'h0000}};
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] address = 4'h0;
  logic [15:0] writeData = 16'h0000;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic [15:0] readData;
  logic timerIrq;
  logic [15:0] got;
  int n_errors = 0;
  int total_checks = 0;
  int gap;
  always #5 clock = ~clock;
  prescaled_interval_timer dut_u (.clock(clock), .rstn(rstn), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .timerIrq(timerIrq));
  task close_out;
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one write cycle; the strobe stays up for a following write, the next task or caller lowers it
  task wr(input logic [3:0] a, input logic [15:0] d);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
  endtask
  // one read cycle, data taken the cycle after
  task rd(input logic [3:0] a);
    address <= a;
    writeStrobe <= 1'b0;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 got = readData;
  endtask
  // cycles to the next interrupt pulse, at most 300
  task waitIrq;
    gap = 0;
    do begin
      @(posedge clock);
      #1 gap++;
    end while (timerIrq !== 1'b1 && gap < 300);
  endtask
  initial begin
    #50000 n_errors++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a);
      chk("readback", ROWS[i].e, got);
    end
    wr(ADDR_PRESCALE, 16'h0002);
    wr(ADDR_PERIOD, 16'h0003);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_CONTROL, 16'h0001);
    writeStrobe <= 1'b0;
    repeat (2) @(posedge clock);
    rd(ADDR_STATUS);
    chk("status", 16'h0001, got);
    waitIrq();
    waitIrq();
    chk("irq gap", 16'((3 + 1) * (2 + 1)), 16'(gap));
    rd(ADDR_STATUS);
    chk("status", 16'h0003, got);
    wr(ADDR_CONTROL, 16'h0000);
    writeStrobe <= 1'b0;
    repeat (2) @(posedge clock);
    rd(ADDR_STATUS);
    chk("status", 16'h0000, got);
    waitIrq();
    chk("irq gap", 16'd300, 16'(gap));
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(ADDR_PERIOD);
    chk("period", PERIOD_RESET, got);
    rd(ADDR_PRESCALE);
    chk("prescale", {8'h00, PRESCALE_RESET}, got);
    close_out();
  end
endmodule // prescaled_interval_timer_tb
